//--- rtl/ast_pkg.sv
// Constants for the asynchronous serial transmitter block
package ast_pkg;
  // ==========================================================================
  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_TX_DATA   = 8'h00;
  localparam logic [7:0] ADDR_RX_DATA   = 8'h04;
  localparam logic [7:0] ADDR_BAUD_LOW  = 8'h08;
  localparam logic [7:0] ADDR_BAUD_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_RX_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_BAUD_CTRL = 8'h18;
  localparam logic [7:0] ADDR_FLAGS     = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int TXC_ENABLE  = 0;
  localparam int TXC_SYNC    = 1;
  localparam int TXC_NINE    = 2;
  localparam int TXC_NINTH_D = 3;
  localparam int TXC_SR_IDLE = 4;
  localparam int RXC_SERIAL_PORT_ENABLE    = 0;
  localparam int RXC_NINE    = 1;
  localparam int RXC_NINTH_D = 2;
  localparam int BDC_INVERT  = 0;
  localparam int BDC_WIDE    = 1;
  localparam int FLG_TX_EMPTY = 0;
  localparam int FLG_RX_READY = 1;
  localparam int IEN_TX_EMPTY = 0;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [15:0] BAUD_RESET       = 16'h0000;
  localparam int          INSTR_CYCLE_CLKS = 4;
  localparam int          FLAG_HOLD_CLKS   = 2 * INSTR_CYCLE_CLKS - 1;
  localparam logic [3:0]  FRAME_BITS_8     = 4'hA;
  localparam logic [3:0]  FRAME_BITS_9     = 4'hB;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_type;
endpackage

//--- rtl/ast_transmitter.sv
// Asynchronous serial transmitter with baud generator, receive path and APB registers
// How it works
// - Line uses NRZ levels and rests at mark when nothing is sent.
// - Frame is one start bit, eight or nine data bits, one stop bit.
// - Start bit is space, stop bit is mark.
// - Every bit lasts exactly one baud period.
// - Baud generator is selectable as 8 or 16 bits wide.
// - Data bits go least significant first, right after the start bit.
// - Receive and transmit share baud but have separate nine-bit selects; ninth bit may carry software parity.
// - Serial port enable turns the transmit pin into an output.
// - Turning the transmitter on sets the buffer empty flag.
// - A write to an empty shifter moves the data in at once.
// - A queued character loads right after the stop bit and starts at once.
// - Polarity bit inverts idle and data levels on the line.
// - Empty flag clear while a character waits in the buffer or the transmitter is off.
// - Empty flag shows the new state from the second instruction cycle after a write.
// - Empty flag is read-only.
// - Interrupt request only when enabled; the flag follows the buffer regardless.
// - Received data and ninth bit are double buffered.
// - Transmit data and ninth bit are double buffered.
// - Writing the low baud byte resets the baud counter.
// - Shift register is loaded only from the buffer and is hidden from software.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module ast_transmitter #(
  parameter int BAUD_WIDTH = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rx_pin_in,
  output logic             transmit_clock_pin_out,
  output logic             transmit_clock_pin_oe_n,
  output logic             tx_irq_req
);
  // ==========================================================================
  // Register state
  logic [7:0]            tx_buf_ff;
  logic                  tx_buf9_ff;
  logic                  buf_full_ff;
  logic [BAUD_WIDTH-1:0] baud_div_ff;
  logic                  transmitter_enable_ff;
  logic                  sync_ff;
  logic                  tx_nine_ff;
  logic                  tx_ninth_ff;
  logic                  serial_port_enable_ff;
  logic                  rx_nine_ff;
  logic                  invert_ff;
  logic                  wide_ff;
  logic                  irq_en_ff;
  logic [31:0]           prdata_ff;
  logic                  flag_ff;
  logic [3:0]            hold_ff;

  // ==========================================================================
  // Transmit and receive state
  logic [BAUD_WIDTH-1:0] brg_cnt_ff;
  logic [10:0]           shift_ff;
  logic [3:0]            bits_ff;
  logic                  busy_ff;
  logic                  line_ff;
  logic                  rx_s1_ff;
  logic                  rx_s2_ff;
  logic                  rx_prev_ff;
  ast_pkg::ast_rx_state_type rx_state_ff;
  logic [BAUD_WIDTH-1:0] rx_cnt_ff;
  logic [3:0]            rx_idx_ff;
  logic [8:0]            rx_shift_ff;
  logic [7:0]            rx_hold_ff;
  logic                  rx_hold9_ff;
  logic                  rx_ready_ff;

  logic                  setup;
  logic                  access;
  logic                  wr;
  logic                  mapped;
  logic                  tx_write;
  logic                  low_write;
  logic                  rx_read;
  logic                  enabled;
  logic [BAUD_WIDTH-1:0] period;
  logic                  tick;
  logic                  shifter_free;
  logic                  load;
  logic                  nxt_flag;
  logic [31:0]           nxt_prdata;

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign tx_write  = wr && paddr == ast_pkg::ADDR_TX_DATA;
  assign low_write = wr && paddr == ast_pkg::ADDR_BAUD_LOW;
  assign rx_read   = access && !pwrite && paddr == ast_pkg::ADDR_RX_DATA;
  assign enabled   = serial_port_enable_ff && transmitter_enable_ff && !sync_ff;

  // Map is dense from offset zero up to the last register
  assign mapped    = paddr <= ast_pkg::ADDR_IRQ_EN && paddr[1:0] == 2'b00;

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_ff;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      ast_pkg::ADDR_TX_DATA:   nxt_prdata[7:0] = tx_buf_ff;
      ast_pkg::ADDR_RX_DATA:   nxt_prdata[7:0] = rx_hold_ff;
      ast_pkg::ADDR_BAUD_LOW:  nxt_prdata[7:0] = baud_div_ff[7:0];
      ast_pkg::ADDR_BAUD_HIGH: nxt_prdata[7:0] = baud_div_ff[15:8];
      ast_pkg::ADDR_TX_CTRL: begin
        nxt_prdata[ast_pkg::TXC_ENABLE]  = transmitter_enable_ff;
        nxt_prdata[ast_pkg::TXC_SYNC]    = sync_ff;
        nxt_prdata[ast_pkg::TXC_NINE]    = tx_nine_ff;
        nxt_prdata[ast_pkg::TXC_NINTH_D] = tx_ninth_ff;
        nxt_prdata[ast_pkg::TXC_SR_IDLE] = !busy_ff;
      end
      ast_pkg::ADDR_RX_CTRL: begin
        nxt_prdata[ast_pkg::RXC_SERIAL_PORT_ENABLE]    = serial_port_enable_ff;
        nxt_prdata[ast_pkg::RXC_NINE]    = rx_nine_ff;
        nxt_prdata[ast_pkg::RXC_NINTH_D] = rx_hold9_ff;
      end
      ast_pkg::ADDR_BAUD_CTRL: begin
        nxt_prdata[ast_pkg::BDC_INVERT] = invert_ff;
        nxt_prdata[ast_pkg::BDC_WIDE]   = wide_ff;
      end
      ast_pkg::ADDR_FLAGS: begin
        nxt_prdata[ast_pkg::FLG_TX_EMPTY] = flag_ff;
        nxt_prdata[ast_pkg::FLG_RX_READY] = rx_ready_ff;
      end
      ast_pkg::ADDR_IRQ_EN: nxt_prdata[ast_pkg::IEN_TX_EMPTY] = irq_en_ff;
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Control registers; the empty flag has no write path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      baud_div_ff <= ast_pkg::BAUD_RESET;
      transmitter_enable_ff     <= 1'b0;
      sync_ff     <= 1'b0;
      tx_nine_ff  <= 1'b0;
      tx_ninth_ff <= 1'b0;
      serial_port_enable_ff     <= 1'b0;
      rx_nine_ff  <= 1'b0;
      invert_ff   <= 1'b0;
      wide_ff     <= 1'b0;
      irq_en_ff   <= 1'b0;
    end else if (wr) begin
      case (paddr)
        ast_pkg::ADDR_BAUD_LOW:  baud_div_ff[7:0]  <= pwdata[7:0];
        ast_pkg::ADDR_BAUD_HIGH: baud_div_ff[15:8] <= pwdata[7:0];
        ast_pkg::ADDR_TX_CTRL: begin
          transmitter_enable_ff     <= pwdata[ast_pkg::TXC_ENABLE];
          sync_ff     <= pwdata[ast_pkg::TXC_SYNC];
          tx_nine_ff  <= pwdata[ast_pkg::TXC_NINE];
          tx_ninth_ff <= pwdata[ast_pkg::TXC_NINTH_D];
        end
        ast_pkg::ADDR_RX_CTRL: begin
          serial_port_enable_ff    <= pwdata[ast_pkg::RXC_SERIAL_PORT_ENABLE];
          rx_nine_ff <= pwdata[ast_pkg::RXC_NINE];
        end
        ast_pkg::ADDR_BAUD_CTRL: begin
          invert_ff <= pwdata[ast_pkg::BDC_INVERT];
          wide_ff   <= pwdata[ast_pkg::BDC_WIDE];
        end
        ast_pkg::ADDR_IRQ_EN: irq_en_ff <= pwdata[ast_pkg::IEN_TX_EMPTY];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Baud generator: period is divisor plus one clocks
  assign period = wide_ff ? baud_div_ff : {8'h00, baud_div_ff[7:0]};
  assign tick   = brg_cnt_ff == period;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brg_cnt_ff <= ast_pkg::BAUD_RESET;
    end else if (low_write || load || tick) begin
      brg_cnt_ff <= ast_pkg::BAUD_RESET;
    end else begin
      brg_cnt_ff <= brg_cnt_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Transmit buffer, one character deep in front of the shifter
  assign shifter_free = !busy_ff || (tick && bits_ff == 4'h1);
  assign load         = enabled && buf_full_ff && shifter_free;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_buf_ff   <= ast_pkg::BYTE_RESET;
      tx_buf9_ff  <= 1'b0;
      buf_full_ff <= 1'b0;
    end else if (tx_write) begin
      tx_buf_ff   <= pwdata[7:0];
      tx_buf9_ff  <= tx_ninth_ff;
      buf_full_ff <= 1'b1;
    end else if (load) begin
      buf_full_ff <= 1'b0;
    end
  end

  // Shifter; software never reaches it except through the buffer
  always_ff @(posedge clk) begin
    if (sys_rst || !enabled) begin
      shift_ff <= 11'h7FF;
      bits_ff  <= 4'h0;
      busy_ff  <= 1'b0;
      line_ff  <= 1'b1;
    end else if (load) begin
      shift_ff <= {1'b1, tx_nine_ff ? tx_buf9_ff : 1'b1, tx_buf_ff, 1'b0};
      bits_ff  <= tx_nine_ff ? ast_pkg::FRAME_BITS_9 : ast_pkg::FRAME_BITS_8;
      busy_ff  <= 1'b1;
      line_ff  <= 1'b0;
    end else if (busy_ff && tick) begin
      shift_ff <= {1'b1, shift_ff[10:1]};
      bits_ff  <= bits_ff - 4'h1;
      busy_ff  <= bits_ff != 4'h1;
      line_ff  <= bits_ff == 4'h1 ? 1'b1 : shift_ff[1];
    end
  end

  assign transmit_clock_pin_out  = line_ff ^ invert_ff;
  assign transmit_clock_pin_oe_n = !serial_port_enable_ff;

  // ==========================================================================
  // Empty flag; a write freezes it so early polling sees the old state
  assign nxt_flag = transmitter_enable_ff && !buf_full_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_ff <= 1'b0;
      hold_ff <= 4'h0;
    end else if (tx_write) begin
      hold_ff <= 4'(ast_pkg::FLAG_HOLD_CLKS);
    end else if (hold_ff != 4'h0) begin
      hold_ff <= hold_ff - 4'h1;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign tx_irq_req = flag_ff && irq_en_ff;

  // ==========================================================================
  // Receive path, mid-bit sampling, result held while the next arrives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_s1_ff   <= 1'b1;
      rx_s2_ff   <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff   <= rx_pin_in;
      rx_s2_ff   <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !serial_port_enable_ff) begin
      rx_state_ff <= ast_pkg::RX_IDLE;
      rx_cnt_ff   <= ast_pkg::BAUD_RESET;
      rx_idx_ff   <= 4'h0;
      rx_shift_ff <= 9'h000;
    end else begin
      rx_cnt_ff <= rx_cnt_ff + 16'h0001;
      case (rx_state_ff)
        ast_pkg::RX_IDLE: begin
          rx_cnt_ff <= ast_pkg::BAUD_RESET;
          if (rx_prev_ff && !rx_s2_ff) begin
            rx_state_ff <= ast_pkg::RX_START;
          end
        end
        ast_pkg::RX_START: begin
          if (rx_cnt_ff == (period >> 1)) begin
            rx_cnt_ff   <= ast_pkg::BAUD_RESET;
            rx_idx_ff   <= 4'h0;
            rx_state_ff <= rx_s2_ff ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
          end
        end
        ast_pkg::RX_DATA: begin
          if (rx_cnt_ff == period) begin
            rx_cnt_ff   <= ast_pkg::BAUD_RESET;
            rx_shift_ff <= {rx_s2_ff, rx_shift_ff[8:1]};
            rx_idx_ff   <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == (rx_nine_ff ? 4'h8 : 4'h7)) begin
              rx_state_ff <= ast_pkg::RX_STOP;
            end
          end
        end
        ast_pkg::RX_STOP: begin
          if (rx_cnt_ff == period) begin
            rx_state_ff <= ast_pkg::RX_IDLE;
          end
        end
        default: rx_state_ff <= ast_pkg::RX_IDLE;
      endcase
    end
  end

  // Good stop bit moves the character into the holding register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_hold_ff  <= ast_pkg::BYTE_RESET;
      rx_hold9_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
    end else if (serial_port_enable_ff && rx_state_ff == ast_pkg::RX_STOP && rx_cnt_ff == period && rx_s2_ff) begin
      rx_hold_ff  <= rx_nine_ff ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
      rx_hold9_ff <= rx_nine_ff && rx_shift_ff[8];
      rx_ready_ff <= 1'b1;
    end else if (rx_read) begin
      rx_ready_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_idle_mark;
    !busy_ff |-> transmit_clock_pin_out == !invert_ff;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not idle at mark");

  property p_start_space;
    load |=> busy_ff && line_ff == 1'b0 && bits_ff >= ast_pkg::FRAME_BITS_8;
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not space");

  property p_bit_hold;
    busy_ff && $changed(line_ff) |-> $past(tick) || $past(load);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit changed mid period");

  property p_stop_mark;
    busy_ff && bits_ff == 4'h1 |-> line_ff == 1'b1;
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("stop bit not mark");

  property p_flag_on_enable;
    $rose(transmitter_enable_ff) && !buf_full_ff && hold_ff == 4'h0 && !tx_write |=> flag_ff;
  endproperty
  a_flag_on_enable: assert property (p_flag_on_enable) else $error("flag not set on enable");

  property p_flag_delay;
    tx_write |=> $stable(flag_ff) [*7] ##1 (flag_ff == nxt_flag || $past(tx_write) || $past(hold_ff) != 4'h0);
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag timing after write wrong");

  property p_baud_reset;
    low_write |=> brg_cnt_ff == ast_pkg::BAUD_RESET;
  endproperty
  a_baud_reset: assert property (p_baud_reset) else $error("baud counter not reset");

  property p_no_load_disabled;
    !(serial_port_enable_ff && transmitter_enable_ff) |-> !load ##1 !busy_ff;
  endproperty
  a_no_load_disabled: assert property (p_no_load_disabled) else $error("load while disabled");

  property p_queue_loads;
    enabled && buf_full_ff && busy_ff && tick && bits_ff == 4'h1 |=> busy_ff && line_ff == 1'b0;
  endproperty
  a_queue_loads: assert property (p_queue_loads) else $error("queued char not started");

  property p_pin_output;
    serial_port_enable_ff |-> !transmit_clock_pin_oe_n;
  endproperty
  a_pin_output: assert property (p_pin_output) else $error("pin not output");

  property p_irq_gate;
    tx_irq_req |-> irq_en_ff && flag_ff;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
endmodule

//--- test/ast_line_rx.sv
// Behavioural remote receiver watching the transmit line
`timescale 1ns/1ps
module ast_line_rx #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic  clk,
  input  wire logic  line,
  input  wire logic  nine,
  output logic [8:0] data,
  output logic       frame_ok,
  output logic       got
);
  logic [8:0] v;
  logic       f;

  // ==========
  // Frame capture at mid-bit; drift of a clock per bit shows up by bit 2
  initial begin
    data = 9'h000;
    frame_ok = 1'b0;
    got = 1'b0;
    forever begin
      @(posedge clk);
      got <= 1'b0;
      if (line === 1'b0) begin
        v = 9'h000;
        repeat (BIT_CLKS / 2) @(posedge clk);
        f = (line === 1'b0);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_CLKS) @(posedge clk);
          v[i] = line;
        end
        repeat (BIT_CLKS) @(posedge clk);
        f = f & (line === 1'b1);
        data <= v;
        frame_ok <= f;
        got <= 1'b1;
      end
    end
  end
endmodule

//--- test/tb.sv
// Self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pin;
  logic        oe_n;
  logic        irq;
  logic        inv;
  logic        nine;
  logic [8:0]  rx_data;
  logic        rx_ok;
  logic        rx_got;
  logic        err_q;
  int          fail_count;
  int          n_checks;
  time         t_got;

  ast_transmitter #(.BAUD_WIDTH(16)) i_dut (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pready                  (pready),
    .prdata                  (prdata),
    .pslverr                 (pslverr),
    .rx_pin_in               (pin ^ inv),
    .transmit_clock_pin_out  (pin),
    .transmit_clock_pin_oe_n (oe_n),
    .tx_irq_req              (irq)
  );

  // Divisor 3 gives four clocks a bit
  ast_line_rx #(.BIT_CLKS(4)) i_far (
    .clk      (clk),
    .line     (pin ^ inv),
    .nine     (nine),
    .data     (rx_data),
    .frame_ok (rx_ok),
    .got      (rx_got)
  );

  always #4 clk = ~clk;

  // ==========
  // Shared tasks
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      summarize();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic rx_expect(input logic [8:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_got !== 1'b1 && n < 400);
    if (n >= 400) begin
      fail_count++;
      summarize();
    end
    t_got = $time;
    chk({22'h0, rx_ok, rx_data}, {22'h0, 1'b1, e});
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    chk({29'h0, pin, oe_n, irq}, 32'h6);
    rd(ast_pkg::ADDR_TX_DATA, 32'h0);
    rd(ast_pkg::ADDR_BAUD_LOW, 32'h0);
    rd(ast_pkg::ADDR_RX_DATA, 32'h0);
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    rd(8'h24, 32'h0);
    chk({31'h0, err_q}, 32'h1);
  endtask

  task automatic t_enable();
    wr(ast_pkg::ADDR_BAUD_LOW, 32'h3);
    wr(ast_pkg::ADDR_RX_CTRL, 32'h1);
    chk({31'h0, oe_n}, 32'h0);
    wr(ast_pkg::ADDR_TX_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    rd(ast_pkg::ADDR_FLAGS, 32'h1);
    wr(ast_pkg::ADDR_FLAGS, 32'h0);
    rd(ast_pkg::ADDR_FLAGS, 32'h1);
  endtask

  task automatic t_single();
    wr(ast_pkg::ADDR_TX_DATA, 32'hA5);
    rd(ast_pkg::ADDR_TX_DATA, 32'hA5);
    rx_expect(9'h0A5);
    repeat (8) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    rd(ast_pkg::ADDR_RX_DATA, 32'hA5);
  endtask

  task automatic t_queue();
    time t0;
    wr(ast_pkg::ADDR_IRQ_EN, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(ast_pkg::ADDR_TX_DATA, 32'h3C);
    wr(ast_pkg::ADDR_TX_DATA, 32'hC3);
    rd(ast_pkg::ADDR_FLAGS, 32'h1);
    repeat (8) @(posedge clk);
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ast_pkg::ADDR_IRQ_EN, 32'h0);
    rx_expect(9'h03C);
    t0 = t_got;
    rx_expect(9'h0C3);
    chk(32'(t_got - t0), 32'h140);
    // Looped-back receiver finishes its stop sample two clocks after the far side
    repeat (4) @(posedge clk);
    rd(ast_pkg::ADDR_FLAGS, 32'h3);
    rd(ast_pkg::ADDR_RX_DATA, 32'hC3);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_nine();
    repeat (4) @(posedge clk);
    nine <= 1'b1;
    wr(ast_pkg::ADDR_TX_CTRL, 32'hD);
    wr(ast_pkg::ADDR_TX_DATA, 32'h55);
    rx_expect(9'h155);
    repeat (4) @(posedge clk);
    wr(ast_pkg::ADDR_TX_CTRL, 32'h1);
    nine <= 1'b0;
  endtask

  task automatic t_invert();
    wr(ast_pkg::ADDR_BAUD_HIGH, 32'h0);
    wr(ast_pkg::ADDR_BAUD_CTRL, 32'h3);
    chk({31'h0, pin}, 32'h0);
    inv <= 1'b1;
    // Let the far side discard the edge caused by the flip
    repeat (60) @(posedge clk);
    wr(ast_pkg::ADDR_TX_DATA, 32'h96);
    rx_expect(9'h096);
    repeat (4) @(posedge clk);
    rd(ast_pkg::ADDR_RX_DATA, 32'h96);
  endtask

  task automatic t_disable();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    wr(ast_pkg::ADDR_TX_CTRL, 32'h0);
    wr(ast_pkg::ADDR_TX_DATA, 32'h0F);
    repeat (60) begin
      @(posedge clk);
      if ((pin ^ inv) !== 1'b1 || rx_got !== 1'b0) begin
        n++;
      end
    end
    chk(32'(n), 32'h0);
    rd(ast_pkg::ADDR_FLAGS, 32'h0);
    wr(ast_pkg::ADDR_RX_CTRL, 32'h0);
    chk({31'h0, oe_n}, 32'h1);
  endtask

  // ==========
  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    inv = 1'b0;
    nine = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_enable();
    t_single();
    t_queue();
    t_nine();
    t_invert();
    t_disable();
    summarize();
  end
endmodule
